// >>> verilog/ssr_pkg.sv
// source select resolver package: sizes, table entry layouts and the
// request and answer carriers shared by the resolver and its input stage.
// assumes one system clock; panel pins arrive asynchronously to it.
package ssr_pkg;

	// ************************************************************
	// sizes of tables and identifiers
	// ************************************************************
	localparam int SSR_BUTTONS = 36;        // buttons per layer on one panel
	localparam int SSR_LAYERS = 2;          // unshifted and shifted layers
	localparam int SSR_PANELS = 2;          // main panel bank and local aux panel
	localparam int SSR_BUSES = 12;          // source selection buses
	localparam int SSR_IDS = 128;           // logical and engineering id space
	localparam int SSR_ID_W = 7;
	localparam int SSR_BTN_W = 6;
	localparam int SSR_BUS_W = 4;
	localparam int SSR_PNL_W = 1;
	localparam int SSR_IN_W = 7;            // physical input number
	localparam int SSR_KP_W = 2;            // default key processing code
	localparam logic [SSR_BTN_W-1:0] SSR_BTN_LIMIT = 6'h24;
	localparam logic [SSR_BUS_W-1:0] SSR_BUS_LIMIT = 4'hC;

	// ************************************************************
	// encodings
	// ************************************************************
	localparam logic SSR_LAYER_UNSHIFT = 1'h0;
	localparam logic SSR_LAYER_SHIFT = 1'h1;

	typedef enum logic [0:0] {
		SSR_IDLE = 1'b0,
		SSR_APPLY = 1'b1
	} ssr_phase_t;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic press;
		logic shift_held;
		logic unshift_held;
		logic [SSR_PNL_W-1:0] panel;
		logic [SSR_BUS_W-1:0] bus;
		logic [SSR_BTN_W-1:0] button;
	} ssr_panel_t;

	typedef struct packed {
		logic valid;
		logic [SSR_ID_W-1:0] logical;
	} ssr_map_entry_t;

	typedef struct packed {
		logic we;
		logic [SSR_PNL_W-1:0] panel;
		logic layer;
		logic [SSR_BTN_W-1:0] button;
		ssr_map_entry_t entry;
	} ssr_map_wr_t;

	typedef struct packed {
		logic we;
		logic [SSR_ID_W-1:0] logical;
		logic [SSR_ID_W-1:0] eng;
	} ssr_patch_wr_t;

	typedef struct packed {
		logic has_key;                      // 0 video only, 1 video and key
		logic [SSR_IN_W-1:0] video_in;
		logic [SSR_IN_W-1:0] key_in;
		logic [SSR_KP_W-1:0] key_proc;
	} ssr_def_t;

	typedef struct packed {
		logic we;
		logic [SSR_ID_W-1:0] eng;
		ssr_def_t def;
	} ssr_def_wr_t;

	typedef struct packed {
		logic we;
		logic [SSR_BUS_W-1:0] bus;
		logic [SSR_ID_W-1:0] logical;
	} ssr_recall_t;

	typedef struct packed {
		logic update;
		logic [SSR_BUS_W-1:0] bus;
		logic [SSR_IN_W-1:0] fill_in;
		logic cut_en;
		logic [SSR_IN_W-1:0] cut_in;
		logic [SSR_KP_W-1:0] key_proc;
		logic [SSR_ID_W-1:0] logical;
		logic [SSR_ID_W-1:0] eng;
	} ssr_xpt_t;

	typedef struct packed {
		logic strobe;
		logic [SSR_BUS_W-1:0] bus;
		logic [SSR_ID_W-1:0] logical;
	} ssr_mem_req_t;

endpackage

// >>> verilog/ssr_panel_sync.sv
// two flip-flop synchroniser for the whole panel input group.
// assumes the panel holds button, bus and modifiers steady around a press.
`timescale 1ns/1ps
`default_nettype none

module ssr_panel_sync (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// asynchronous panel pins
	input wire ssr_pkg::ssr_panel_t pins,
	// synchronised copy
	output var ssr_pkg::ssr_panel_t pins_sync
);
	import ssr_pkg::*;

	typedef struct packed {
		ssr_panel_t meta;
		ssr_panel_t stable;
	} ssr_sync_state_t;

	ssr_sync_state_t s_reg;
	ssr_sync_state_t s_next;

	// ************************************************************
	// next state: first stage feeds only the second
	// ************************************************************
	always_comb begin
		s_next.meta = pins;
		s_next.stable = s_reg.meta;
	end

	// state register with synchronous reset
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs
	assign pins_sync = s_reg.stable;

endmodule
`default_nettype wire

// >>> verilog/ssr_resolver.sv
// source select resolver: turns a panel source-button press into one
// crosspoint update for a fill bus and its cut bus.
// assumes table writes and recalls come from logic on mclk; panel pins
// are asynchronous and pass the two flip-flop input stage.
// Function
// - with shift held a press takes the shifted source of that button whatever the bus preference.
// - with unshift held and shift not held a press takes the unshifted source whatever the bus preference.
// - with no modifier a shifted-preference bus takes the shifted source.
// - with no modifier an unshifted-preference bus takes the unshifted source.
// - a button with only one mapped source gives that source regardless of preference or modifiers.
// - the mapping holds 72 sources per panel, 36 per layer.
// - every bus has its own shift preference bit that picks the default layer.
// - a video-and-key source puts its video on the fill bus and its key on the cut bus at once.
// - a video-only source can be routed to both fill and cut buses by one press.
// - a press goes through the button map then the source definition, never fixed wiring.
// - a patch table turns logical ids into engineering ids before inputs are looked up.
// - on-air tally is driven per engineering id.
// - a single definition table gives signal count, physical inputs and default key processing.
// - stored effects carry source ids and recall by id, independent of buttons.
// - each main panel bank and local aux panel has its own button map.
// - selecting a source may request that source's memory entry to be applied.
`timescale 1ns/1ps
`default_nettype none

module ssr_resolver (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// panel buttons and modifiers, asynchronous
	input wire ssr_pkg::ssr_panel_t panel_pins,
	// table loading from the control processor
	input wire ssr_pkg::ssr_map_wr_t map_wr,
	input wire ssr_pkg::ssr_patch_wr_t patch_wr,
	input wire ssr_pkg::ssr_def_wr_t def_wr,
	// effect recall by logical id
	input wire ssr_pkg::ssr_recall_t recall,
	// per-bus configuration and the global memory recall enable
	input wire logic [ssr_pkg::SSR_BUSES-1:0] shift_pref,
	input wire logic [ssr_pkg::SSR_BUSES-1:0] key_bus,
	input wire logic [ssr_pkg::SSR_BUSES-1:0] on_air,
	input wire logic auto_mem_en,
	// crosspoint matrix side
	output var ssr_pkg::ssr_xpt_t xpt,
	output var ssr_pkg::ssr_mem_req_t mem_req,
	output var logic [ssr_pkg::SSR_IDS-1:0] tally,
	output var logic ready
);
	import ssr_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef ssr_map_entry_t [SSR_LAYERS-1:0][SSR_BUTTONS-1:0] ssr_panel_map_t;

	typedef struct packed {
		ssr_panel_map_t [SSR_PANELS-1:0] map;
		logic [SSR_IDS-1:0][SSR_ID_W-1:0] patch;
		ssr_def_t [SSR_IDS-1:0] defs;
		ssr_phase_t phase;
		logic press_prev;
		logic [SSR_BUS_W-1:0] pend_bus;
		logic [SSR_ID_W-1:0] pend_logical;
		logic [SSR_BUSES-1:0][SSR_ID_W-1:0] bus_eng;
		logic [SSR_BUSES-1:0] bus_live;
		ssr_xpt_t xpt;
		ssr_mem_req_t mem;
		logic [SSR_IDS-1:0] tally;
	} ssr_state_t;

	ssr_state_t s_reg;
	ssr_state_t s_next;
	ssr_panel_t pnl;
	logic press_edge;
	ssr_map_entry_t picked;
	logic [SSR_ID_W-1:0] eng;
	ssr_def_t def;

	// ************************************************************
	// functions
	// ************************************************************

	// choose the layer entry for a press
	function automatic ssr_map_entry_t pick_entry(
		input logic shift_held,
		input logic unshift_held,
		input logic pref_shifted,
		input ssr_map_entry_t unsh,
		input ssr_map_entry_t sh
	);
		logic layer;
		layer = pref_shifted ? SSR_LAYER_SHIFT : SSR_LAYER_UNSHIFT;
		if (unshift_held) begin
			layer = SSR_LAYER_UNSHIFT;
		end
		if (shift_held) begin
			layer = SSR_LAYER_SHIFT;
		end
		// a lone mapping wins over layer choice
		if (unsh.valid && !sh.valid) begin
			pick_entry = unsh;
		end else if (sh.valid && !unsh.valid) begin
			pick_entry = sh;
		end else if (layer == SSR_LAYER_SHIFT) begin
			pick_entry = sh;
		end else begin
			pick_entry = unsh;
		end
	endfunction

	// input that feeds the cut bus for a defined source
	function automatic logic [SSR_IN_W-1:0] cut_source(input ssr_def_t d);
		if (d.has_key) begin
			cut_source = d.key_in;
		end else begin
			cut_source = d.video_in;
		end
	endfunction

	// reset image: empty map and definitions, straight-through patch
	function automatic ssr_state_t reset_image();
		ssr_state_t r;
		r = '0;
		for (int i = 0; i < SSR_IDS; i++) begin
			r.patch[i] = SSR_ID_W'(i);
		end
		r.phase = SSR_IDLE;
		reset_image = r;
	endfunction

	// ************************************************************
	// panel input stage
	// ************************************************************
	ssr_panel_sync u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.pins(panel_pins),
		.pins_sync(pnl)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s_next = s_reg;
		eng = '0;
		def = '0;
		picked = '0;
		s_next.xpt.update = 1'b0;
		s_next.mem.strobe = 1'b0;

		// press edge on synchronised button strobe
		press_edge = pnl.press & ~s_reg.press_prev;
		s_next.press_prev = pnl.press;

		// button map writes, one map per panel and layer
		if (map_wr.we && map_wr.button < SSR_BTN_LIMIT) begin
			s_next.map[map_wr.panel][map_wr.layer][map_wr.button] = map_wr.entry;
		end

		// patch table writes retarget later selections
		if (patch_wr.we) begin
			s_next.patch[patch_wr.logical] = patch_wr.eng;
		end

		// single definition table
		if (def_wr.we) begin
			s_next.defs[def_wr.eng] = def_wr.def;
		end

		case (s_reg.phase)
			SSR_IDLE: begin
				// a press has priority over a recall in the same cycle
				if (press_edge && pnl.button < SSR_BTN_LIMIT && pnl.bus < SSR_BUS_LIMIT) begin
					picked = pick_entry(pnl.shift_held, pnl.unshift_held, shift_pref[pnl.bus],
						s_reg.map[pnl.panel][SSR_LAYER_UNSHIFT][pnl.button],
						s_reg.map[pnl.panel][SSR_LAYER_SHIFT][pnl.button]);
					if (picked.valid) begin
						s_next.pend_bus = pnl.bus;
						s_next.pend_logical = picked.logical;
						s_next.phase = SSR_APPLY;
					end
				end else if (recall.we && recall.bus < SSR_BUS_LIMIT) begin
					s_next.pend_bus = recall.bus;
					s_next.pend_logical = recall.logical;
					s_next.phase = SSR_APPLY;
				end
			end
			SSR_APPLY: begin
				// logical id through patch, then definition
				eng = s_reg.patch[s_reg.pend_logical];
				def = s_reg.defs[eng];
				// fill and cut land together in one register update
				s_next.xpt.update = 1'b1;
				s_next.xpt.bus = s_reg.pend_bus;
				s_next.xpt.fill_in = def.video_in;
				s_next.xpt.cut_en = key_bus[s_reg.pend_bus];
				s_next.xpt.cut_in = cut_source(def);
				s_next.xpt.key_proc = def.key_proc;
				s_next.xpt.logical = s_reg.pend_logical;
				s_next.xpt.eng = eng;
				// per-source memory recall request
				s_next.mem.strobe = auto_mem_en;
				s_next.mem.bus = s_reg.pend_bus;
				s_next.mem.logical = s_reg.pend_logical;
				// remember what each bus now carries
				s_next.bus_eng[s_reg.pend_bus] = eng;
				s_next.bus_live[s_reg.pend_bus] = 1'b1;
				s_next.phase = SSR_IDLE;
			end
			default: begin
				s_next.phase = SSR_IDLE;
			end
		endcase

		// tally per engineering id from the buses on air
		s_next.tally = '0;
		for (int b = 0; b < SSR_BUSES; b++) begin
			if (s_next.bus_live[b] && on_air[b]) begin
				s_next.tally[s_next.bus_eng[b]] = 1'b1;
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s_reg <= reset_image();
		end else begin
			s_reg <= s_next;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign xpt = s_reg.xpt;
	assign mem_req = s_reg.mem;
	assign tally = s_reg.tally;
	assign ready = (s_reg.phase == SSR_IDLE); // recall taken only when high

endmodule
`default_nettype wire

// >>> tb/ssr_resolver_props.sv
// checker for the source select resolver, bound to its top module ports.
// assumes one clock mclk and the synchronous active low reset_n.
`timescale 1ns/1ps
`default_nettype none

module ssr_resolver_props (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// watched inputs
	input wire ssr_pkg::ssr_panel_t panel_pins,
	input wire ssr_pkg::ssr_recall_t recall,
	input wire logic [ssr_pkg::SSR_BUSES-1:0] key_bus,
	input wire logic [ssr_pkg::SSR_BUSES-1:0] on_air,
	input wire logic auto_mem_en,
	// watched outputs
	input wire ssr_pkg::ssr_xpt_t xpt,
	input wire ssr_pkg::ssr_mem_req_t mem_req,
	input wire logic [ssr_pkg::SSR_IDS-1:0] tally,
	input wire logic ready
);
	import ssr_pkg::*;

	// ************************************************************
	// crosspoint update properties
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	property p_pulse;
		xpt.update |=> !xpt.update && ready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("update not a single pulse");
	property p_busy;
		xpt.update |-> !$past(ready);
	endproperty
	a_busy: assert property (p_busy) else $error("update without apply phase");
	property p_cut_en;
		xpt.update |-> xpt.cut_en == key_bus[xpt.bus];
	endproperty
	a_cut_en: assert property (p_cut_en) else $error("cut enable wrong");
	property p_hold;
		!xpt.update |-> $stable({xpt.fill_in, xpt.cut_in, xpt.eng, xpt.logical, xpt.bus});
	endproperty
	a_hold: assert property (p_hold) else $error("crosspoint moved without update");
	property p_mem;
		xpt.update && auto_mem_en |-> mem_req.strobe && mem_req.bus == xpt.bus
			&& mem_req.logical == xpt.logical;
	endproperty
	a_mem: assert property (p_mem) else $error("memory request missing");
	property p_mem_cause;
		mem_req.strobe |-> xpt.update;
	endproperty
	a_mem_cause: assert property (p_mem_cause) else $error("stray memory request");
	property p_recall;
		(!panel_pins.press)[*4] ##0 (recall.we && ready && recall.bus < SSR_BUS_LIMIT)
			|-> ##2 (xpt.update && xpt.logical == $past(recall.logical, 2));
	endproperty
	a_recall: assert property (p_recall) else $error("recall not applied");
	property p_tally;
		xpt.update && $stable(on_air) && on_air[xpt.bus] |-> tally[xpt.eng];
	endproperty
	a_tally: assert property (p_tally) else $error("tally not set");
endmodule

bind ssr_resolver ssr_resolver_props u_props (
	.mclk(mclk),
	.reset_n(reset_n),
	.panel_pins(panel_pins),
	.recall(recall),
	.key_bus(key_bus),
	.on_air(on_air),
	.auto_mem_en(auto_mem_en),
	.xpt(xpt),
	.mem_req(mem_req),
	.tally(tally),
	.ready(ready)
);
`default_nettype wire

// >>> tb/ssr_panel_model.sv
// control panel model: source buttons and shift modifiers.
// assumes the bench calls its tasks; lines change just after mclk edges.
`timescale 1ns/1ps
`default_nettype none

module ssr_panel_model (
	// clock
	input wire logic mclk,
	// panel lines toward the resolver
	output var ssr_pkg::ssr_panel_t pins
);
	import ssr_pkg::*;

	// ************************************************************
	// button actions
	// ************************************************************
	// press released at reset so no false edge is seen
	initial begin
		pins = '0;
	end

	// hold a button with its modifiers
	task automatic press_down(input logic p, input logic [3:0] b, input logic [5:0] k,
		input logic sh, input logic un);
		@(posedge mclk);
		pins <= {1'b1, sh, un, p, b, k};
	endtask

	// let go; idle lines then show the inverse of the last value
	task automatic let_go();
		@(posedge mclk);
		pins.press <= 1'b0;
		pins.shift_held <= 1'b0;
		pins.unshift_held <= 1'b0;
		repeat (2) @(posedge mclk);
		pins.bus <= ~pins.bus;
		pins.button <= ~pins.button;
		repeat (3) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// >>> tb/test_ssr_resolver.sv
// bench for the source select resolver: loads tables, presses buttons.
// assumes a 10 MHz mclk and the panel model on the panel pins.
`timescale 1ns/1ps
`default_nettype none

module test_ssr_resolver;
	import ssr_pkg::*;
	logic mclk;
	logic reset_n;
	ssr_panel_t panel_pins;
	ssr_map_wr_t map_wr;
	ssr_patch_wr_t patch_wr;
	ssr_def_wr_t def_wr;
	ssr_recall_t recall;
	logic [SSR_BUSES-1:0] shift_pref;
	logic [SSR_BUSES-1:0] key_bus;
	logic [SSR_BUSES-1:0] on_air;
	logic auto_mem_en;
	ssr_xpt_t xpt;
	ssr_mem_req_t mem_req;
	logic [SSR_IDS-1:0] tally;
	logic ready;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;

	// ************************************************************
	// design, panel and clock
	// ************************************************************
	ssr_resolver u_dut (.mclk(mclk), .reset_n(reset_n), .panel_pins(panel_pins),
		.map_wr(map_wr), .patch_wr(patch_wr), .def_wr(def_wr), .recall(recall),
		.shift_pref(shift_pref), .key_bus(key_bus), .on_air(on_air),
		.auto_mem_en(auto_mem_en), .xpt(xpt), .mem_req(mem_req), .tally(tally),
		.ready(ready));
	ssr_panel_model u_pnl (.mclk(mclk), .pins(panel_pins));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic end_sim();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [6:0] exp, input logic [6:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr_map(input logic p, input logic l, input logic [5:0] k, input logic [6:0] id);
		@(posedge mclk);
		map_wr <= {1'b1, p, l, k, 1'b1, id};
		@(posedge mclk);
		map_wr.we <= 1'b0;
	endtask

	task automatic wr_def(input logic [6:0] e, input logic hk, input logic [6:0] v,
		input logic [6:0] k, input logic [1:0] kp);
		@(posedge mclk);
		def_wr <= {1'b1, e, hk, v, k, kp};
		@(posedge mclk);
		def_wr.we <= 1'b0;
	endtask

	// bounded wait for the crosspoint update pulse; ready must drop in the apply cycle
	task automatic wait_update();
		int i;
		logic rdy;
		rdy = 1'b1;
		#1;
		for (i = 0; i < 12 && xpt.update !== 1'b1; i++) begin
			rdy = ready;
			@(posedge mclk);
			#1;
		end
		check("update", 7'h01, {6'h00, xpt.update});
		check("busy", 7'h00, {6'h00, rdy});
		check("ready", 7'h01, {6'h00, ready});
	endtask

	// press, then compare the crosspoint word against the loaded tables
	task automatic sel(input logic p, input logic [3:0] b, input logic [5:0] k,
		input logic sh, input logic un, input logic [6:0] lg, input logic [6:0] e);
		u_pnl.press_down(p, b, k, sh, un);
		wait_update();
		check("logical", lg, xpt.logical);
		check("eng", e, xpt.eng);
		check("fill", (e == 7'h05) ? 7'h10 : 7'h20, xpt.fill_in);
		check("cut", (e == 7'h05) ? 7'h11 : 7'h20, xpt.cut_in);
		check("proc", (e == 7'h05) ? 7'h02 : 7'h01, {5'h00, xpt.key_proc});
		check("tally", {6'h00, on_air[b]}, {6'h00, tally[e]});
		check("bus", {3'h0, b}, {3'h0, xpt.bus});
		check("cut_en", {6'h00, key_bus[b]}, {6'h00, xpt.cut_en});
		check("mem_strobe", 7'h01, {6'h00, mem_req.strobe});
		check("mem_logical", lg, mem_req.logical);
		u_pnl.let_go();
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			end_sim();
		end
	end

	initial begin
		reset_n = 1'b0;
		map_wr = '0;
		patch_wr = '0;
		def_wr = '0;
		recall = '0;
		shift_pref = 12'h002;
		key_bus = 12'h7FF;
		on_air = 12'h001;
		auto_mem_en = 1'b1;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		wr_def(7'h05, 1'b1, 7'h10, 7'h11, 2'h2);
		wr_def(7'h06, 1'b0, 7'h20, 7'h7F, 2'h1);
		wr_map(1'b0, 1'b0, 6'h03, 7'h05);
		wr_map(1'b0, 1'b1, 6'h03, 7'h06);
		wr_map(1'b0, 1'b1, 6'h04, 7'h05);
		wr_map(1'b1, 1'b0, 6'h03, 7'h06);
		wr_map(1'b0, 1'b1, 6'h23, 7'h05);
		sel(1'b0, 4'h0, 6'h03, 1'b0, 1'b0, 7'h05, 7'h05);
		sel(1'b0, 4'h1, 6'h03, 1'b0, 1'b0, 7'h06, 7'h06);
		sel(1'b0, 4'h0, 6'h03, 1'b1, 1'b0, 7'h06, 7'h06);
		sel(1'b0, 4'h1, 6'h03, 1'b0, 1'b1, 7'h05, 7'h05);
		sel(1'b0, 4'h0, 6'h04, 1'b0, 1'b1, 7'h05, 7'h05);
		sel(1'b1, 4'h0, 6'h03, 1'b0, 1'b0, 7'h06, 7'h06);
		sel(1'b0, 4'h1, 6'h23, 1'b0, 1'b0, 7'h05, 7'h05);
		sel(1'b0, 4'hB, 6'h03, 1'b0, 1'b0, 7'h05, 7'h05);
		@(posedge mclk);
		patch_wr <= {1'b1, 7'h05, 7'h06};
		@(posedge mclk);
		patch_wr.we <= 1'b0;
		sel(1'b0, 4'h0, 6'h03, 1'b0, 1'b0, 7'h05, 7'h06);
		@(posedge mclk);
		recall <= {1'b1, 4'h1, 7'h06};
		auto_mem_en <= 1'b0;
		@(posedge mclk);
		recall.we <= 1'b0;
		wait_update();
		check("recall", 7'h06, xpt.logical);
		check("recall_bus", 7'h01, {3'h0, xpt.bus});
		check("recall_mem", 7'h00, {6'h00, mem_req.strobe});
		end_sim();
	end
endmodule
`default_nettype wire
